// >>> common/tst_chan_if.sv
/*
 * Link between the trigger top and one pin channel.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface tst_chan_if;
  logic sample_tick;
  logic [5:0] filter_count;
  logic [1:0] edge_select;
  logic count_clear;
  logic level;
  tst_pkg::tst_count_t count;
  logic fire;
  modport ctrl(output sample_tick, filter_count, edge_select, count_clear,
               input level, count, fire);
  modport chan(input sample_tick, filter_count, edge_select, count_clear,
               output level, count, fire);
endinterface : tst_chan_if

// >>> common/tst_consts.svh
/*
 * Named constants of the time-stamp trigger front end.
 * Assumes a 40 MHz clock derived from the RTC timebase.
 */
// How it works
// R1: Each pin's three-bit pull select picks none, up 500k, up 1M (reset), up 10M or down 500k, other codes none.
// R2: Each pin is sampled every 125 ms and a new level is accepted after filter count matching samples.
// R3: With a filter count of zero the source must hold a pulse at least 1 ms.
// R4: Software never programs a filter count of one or of 0x29 and above.
// R5: For counts 2 to 40 a pulse of count times 125 ms is always caught.
// R6: A detected pin event is fetched and captured 5 ms after detection.
// R7: The two-bit edge select picks falling (reset), rising or both edges.
// R8: Each pin has a readable 6-bit counter of accepted events from 0 to 63.
// R9: A pin counter stops at 63 until it is cleared.
// R10: Each pin has a readable monitor bit with its present level.
// R11: Battery drop, either supply threshold drop and oscillation stop raise internal triggers.
// R12: An oscillation stop is captured only once the oscillator runs again.
// R13: Supply drops are detected only while the switch init enable bit is 1.
// R14: With the command enable set, any command register write issues one trigger.
// R15: With the command enable clear, command register writes do nothing.
// R16: Captured records go to a 256-byte internal buffer.
// R17: Any trigger captures the present time stamp and writes the record.
`ifndef TST_CONSTS_SVH
`define TST_CONSTS_SVH
`define TST_CLK_KHZ 40000
`define TST_SAMPLE_MS 125
`define TST_FETCH_MS 5
`define TST_TIMER_W 23
`define TST_PULL_NONE 3'h0
`define TST_PULL_UP_500K 3'h1
`define TST_PULL_UP_1M 3'h2
`define TST_PULL_UP_10M 3'h3
`define TST_PULL_DN_500K 3'h4
// One-hot pull enables sent to the pad; the 1M pull-up is the reset choice.
`define TST_PEN_NONE 4'h0
`define TST_PEN_UP_500K 4'h1
`define TST_PEN_UP_1M 4'h2
`define TST_PEN_UP_10M 4'h4
`define TST_PEN_DN_500K 4'h8
`define TST_EDGE_FALL 2'h0
`define TST_EDGE_RISE 2'h1
`define TST_EDGE_RESET 2'h0
`define TST_CNT_MAX 6'h3f
`define TST_FILT_BYPASS 6'h00
`define TST_F_OSC 0
`define TST_F_SUPPLY_THRESHOLD_ONE 1
`define TST_F_SUPPLY_THRESHOLD_TWO 2
`define TST_F_VBAT 3
`define TST_F_PIN 4
`define TST_F_CMD 7
`define TST_TS_BITS 56
`define TST_REC_ENTRIES 32
`define TST_PTR_W 5
`endif

// >>> common/tst_pkg.sv
/*
 * Types of the time-stamp trigger front end.
 * Assumes nothing beyond the constants header.
 */
package tst_pkg;
  typedef logic [5:0] tst_count_t;
  typedef logic [63:0] tst_record_t;
  typedef enum logic {TST_FETCH_IDLE, TST_FETCH_WAIT} tst_fetch_state_t;
  typedef enum logic {TST_OSC_RUN, TST_OSC_STOPPED} tst_osc_state_t;
endpackage : tst_pkg

// >>> tb/tst_event_source.sv
/*
 * Behavioural source of the three event input pins.
 * Assumes the one-hot pull outputs of the trigger front end and a bench
 * that calls the tasks below from a single process.
 */
`timescale 1ns/10ps
module tst_event_source #(
  parameter int unsigned MIN_HOLD = 2
) (
  input wire logic clock_in,
  input wire logic [3:0] pull_one_in,
  input wire logic [3:0] pull_two_in,
  input wire logic [3:0] pull_three_in,
  output logic [2:0] pin_out
);
  logic [2:0] drive_q = 3'h7;
  logic [2:0] en_q = 3'h7;
  logic [3:0] pull [3];

  // ==========================================================
  // Pin levels
  // A released pin follows its resistor; with none it moves away from the
  // last driven level so that a stale value never passes for a drive.
  assign pull[0] = pull_one_in;
  assign pull[1] = pull_two_in;
  assign pull[2] = pull_three_in;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (en_q[i]) pin_out[i] = drive_q[i];
      else if (|pull[i][2:0]) pin_out[i] = 1'b1;
      else if (pull[i][3]) pin_out[i] = 1'b0;
      else pin_out[i] = ~drive_q[i];
    end
  end

  // ==========================================================
  // Driving tasks
  // Every change lands just after a rising clock edge.
  task automatic drive(input int pin, input logic lvl);
    @(posedge clock_in);
    #2;
    drive_q[pin] = lvl;
    en_q[pin] = 1'b1;
  endtask : drive

  task automatic release_pin(input int pin);
    @(posedge clock_in);
    #2;
    en_q[pin] = 1'b0;
  endtask : release_pin

  // A pulse is never held shorter than the minimum valid width.
  task automatic pulse(input int pin, input logic lvl, input int cyc);
    drive(pin, lvl);
    repeat ((cyc > MIN_HOLD) ? cyc - 1 : MIN_HOLD - 1)
      @(posedge clock_in);
    drive(pin, ~lvl);
  endtask : pulse
endmodule : tst_event_source

// >>> tb/tst_trigger_top_tb.sv
/*
 * Self-checking bench of the time-stamp trigger front end.
 * Assumes shortened sample and fetch counts set through parameters.
 */
`timescale 1ns/10ps
`include "tst_consts.svh"
module tst_trigger_top_tb;
  localparam int SAMPLE = 8;
  localparam int FETCH = 12;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] pin;
  logic [2:0] pull_sel [3];
  logic [1:0] edge_sel [3];
  logic [5:0] filt [3];
  logic [2:0] clr = 3'h0;
  logic bat = 1'b0, thr1 = 1'b0, thr2 = 1'b0, osc = 1'b0;
  logic sw_en = 1'b1, cmd_en = 1'b0, cmd_wr = 1'b0;
  logic [55:0] ts = 56'h0;
  logic [4:0] rd_idx = 5'h0;
  logic [3:0] pull_o [3];
  logic [5:0] cnt_o [3];
  logic [2:0] mon;
  logic strobe;
  logic [7:0] factor;
  logic [4:0] wr_idx;
  logic [63:0] rd_data;
  logic [3:0] pull_exp [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h0,
                               4'h0};
  int error_cnt = 0;
  int checks_done = 0;
  int strobes = 0;

  // ==========================================================
  // Clock, design and pin source
  always #12.5 clock_in = ~clock_in;

  tst_trigger_top #(.SAMPLE_CYC(SAMPLE), .FETCH_CYC(FETCH)) tst_trigger_top_i (
    .clock_in(clock_in), .rst_in(rst_in),
    .event_input_pin_one_in(pin[0]), .event_input_pin_two_in(pin[1]),
    .event_input_pin_three_in(pin[2]),
    .input_one_pull_select_in(pull_sel[0]),
    .input_two_pull_select_in(pull_sel[1]),
    .input_three_pull_select_in(pull_sel[2]),
    .input_one_edge_select_in(edge_sel[0]),
    .input_two_edge_select_in(edge_sel[1]),
    .input_three_edge_select_in(edge_sel[2]),
    .input_one_filter_in(filt[0]), .input_two_filter_in(filt[1]),
    .input_three_filter_in(filt[2]), .counter_clear_in(clr),
    .battery_drop_in(bat), .supply_threshold_one_drop_in(thr1),
    .supply_threshold_two_drop_in(thr2), .osc_stop_in(osc),
    .switch_init_enable_in(sw_en), .command_trigger_enable_in(cmd_en),
    .command_trigger_write_in(cmd_wr), .timestamp_in(ts),
    .record_read_index_in(rd_idx), .input_one_pull_out(pull_o[0]),
    .input_two_pull_out(pull_o[1]), .input_three_pull_out(pull_o[2]),
    .input_one_counter_out(cnt_o[0]), .input_two_counter_out(cnt_o[1]),
    .input_three_counter_out(cnt_o[2]), .pin_level_monitor_out(mon),
    .capture_strobe_out(strobe), .capture_factor_out(factor),
    .record_write_index_out(wr_idx), .record_read_data_out(rd_data));

  tst_event_source tst_event_source_i (
    .clock_in(clock_in), .pull_one_in(pull_o[0]), .pull_two_in(pull_o[1]),
    .pull_three_in(pull_o[2]), .pin_out(pin));

  // Counts every record strobe seen by the bench.
  always @(posedge clock_in) if (strobe === 1'b1) strobes <= strobes + 1;

  // ==========================================================
  // Bench tasks
  task automatic chk(input string name, input logic [63:0] exp,
                     input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask : tick

  // Waits for the next strobe; n is -1 when none comes within limit.
  task automatic wait_strobe(input int limit, output int n);
    n = -1;
    for (int i = 1; i <= limit && n < 0; i++) begin
      @(posedge clock_in);
      #1;
      if (strobe === 1'b1) n = i;
    end
    #1;
  endtask : wait_strobe

  task automatic detector(input int k, input logic [7:0] exp);
    int n;
    case (k)
      0: bat = 1'b1;
      1: thr1 = 1'b1;
      default: thr2 = 1'b1;
    endcase
    wait_strobe(12, n);
    chk("detector record", 1'b1, n > 0);
    chk("detector factor", exp, factor);
    bat = 1'b0;
    thr1 = 1'b0;
    thr2 = 1'b0;
    tick(4);
  endtask : detector

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Test sequence
  initial begin
    int n;
    int s0;
    logic [5:0] c0;
    logic [4:0] idx0;
    for (int i = 0; i < 3; i++) begin
      pull_sel[i] = 3'h2;
      edge_sel[i] = 2'h0;
      filt[i] = 6'h00;
    end
    tick(16);
    rst_in = 1'b0;
    chk("pull reset", 4'h2, pull_o[0]);
    chk("counter reset", 6'h00, cnt_o[0]);
    chk("monitor reset", 3'h7, mon);
    chk("factor reset", 8'h00, factor);
    chk("index reset", 5'h00, wr_idx);
    for (int c = 0; c < 8; c++) begin
      for (int i = 0; i < 3; i++) pull_sel[i] = c[2:0];
      tick(2);
      for (int i = 0; i < 3; i++)
        chk("pull out", pull_exp[c], pull_o[i]);
    end
    pull_sel[0] = 3'h4;
    tst_event_source_i.release_pin(0);
    tick(8);
    chk("monitor pull down", 1'b0, mon[0]);
    pull_sel[0] = 3'h1;
    tick(8);
    chk("monitor pull up", 1'b1, mon[0]);
    tst_event_source_i.drive(0, 1'b1);
    pull_sel[0] = 3'h2;
    tick(FETCH + 8);
    tst_event_source_i.drive(0, 1'b0);
    wait_strobe(FETCH + 20, n);
    chk("fetch delay", 1'b1, n >= FETCH + 4 && n <= FETCH + 9);
    chk("pin factor", 8'h10, factor);
    chk("monitor low", 1'b0, mon[0]);
    tst_event_source_i.drive(0, 1'b1);
    tick(FETCH + 8);
    for (int e = 0; e < 4; e++) begin
      edge_sel[0] = e[1:0];
      s0 = strobes;
      c0 = cnt_o[0];
      tst_event_source_i.pulse(0, 1'b0, FETCH + 8);
      tick(FETCH + 12);
      n = (e > 1) ? 2 : 1;
      chk("edge records", n, strobes - s0);
      chk("edge count", n, 6'(cnt_o[0] - c0));
    end
    filt[1] = 6'h03;
    tick(2);
    s0 = strobes;
    tst_event_source_i.pulse(1, 1'b0, 2 * SAMPLE - 4);
    tick(4 * SAMPLE + FETCH);
    chk("short pulse", 0, strobes - s0);
    tst_event_source_i.pulse(1, 1'b0, 3 * SAMPLE);
    tick(4 * SAMPLE + FETCH);
    chk("long pulse", 1, strobes - s0);
    chk("filtered factor", 8'h20, factor);
    chk("pin two count", 6'h01, cnt_o[1]);
    edge_sel[2] = 2'h2;
    for (int k = 0; k < 35; k++) begin
      tst_event_source_i.pulse(2, 1'b0, 4);
      tick(3);
    end
    tick(FETCH + 8);
    chk("counter top", `TST_CNT_MAX, cnt_o[2]);
    clr = 3'h4;
    tick(1);
    clr = 3'h0;
    tick(1);
    chk("counter cleared", 6'h00, cnt_o[2]);
    ts = 56'h0123456789abcd;
    s0 = strobes;
    cmd_wr = 1'b1;
    tick(1);
    cmd_wr = 1'b0;
    tick(3);
    chk("disabled command", 0, strobes - s0);
    cmd_en = 1'b1;
    idx0 = wr_idx;
    cmd_wr = 1'b1;
    tick(2);
    cmd_wr = 1'b0;
    tick(3);
    chk("command records", 2, strobes - s0);
    chk("command factor", 8'h80, factor);
    chk("index step", 5'(idx0 + 5'h2), wr_idx);
    rd_idx = idx0;
    tick(2);
    chk("record data", {ts, 8'h80}, rd_data);
    sw_en = 1'b0;
    s0 = strobes;
    thr1 = 1'b1;
    tick(12);
    chk("supply drop gated", 0, strobes - s0);
    thr1 = 1'b0;
    sw_en = 1'b1;
    tick(4);
    detector(0, 8'h08);
    detector(1, 8'h02);
    detector(2, 8'h04);
    s0 = strobes;
    osc = 1'b1;
    tick(12);
    chk("osc while stopped", 0, strobes - s0);
    osc = 1'b0;
    wait_strobe(12, n);
    chk("osc factor", 8'h01, factor);
    wrap_up();
  end

  // Cuts a hang short well after the sequence should have ended.
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end
endmodule : tst_trigger_top_tb

// >>> verilog/tst_pin_channel.sv
/*
 * One event input channel: synchroniser, noise filter, edge select,
 * event counter and fetch delay.
 * Assumes the sample tick is a one-cycle pulse every 125 ms.
 */
`timescale 1ns/10ps
`include "tst_consts.svh"
module tst_pin_channel #(
  parameter int unsigned FETCH_CYC = `TST_FETCH_MS * `TST_CLK_KHZ
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic pin_in,
  tst_chan_if.chan ch
);
  // ==========================================================
  // Synchroniser and level monitor
  logic s1_q, s2_q, s3_q, level_q;
  // The level moves only once the second and third stages agree.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) level_q <= s3_q; // [R10]
    end
  end
  assign ch.level = level_q;

  // ==========================================================
  // Noise filter
  logic acc_q, prev_q;
  logic [5:0] run_q;
  // Counts matching samples that differ from the accepted level.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      acc_q <= 1'b1;
      run_q <= 6'h00;
    end else if (ch.filter_count == `TST_FILT_BYPASS) begin
      acc_q <= level_q;
      run_q <= 6'h00;
    end else if (ch.sample_tick) begin
      if (level_q == acc_q) begin
        run_q <= 6'h00; // [R2]
      end else if (7'(run_q) + 7'h01 >= 7'(ch.filter_count)) begin
        acc_q <= level_q; // [R2] [R5]
        run_q <= 6'h00;
      end else begin
        run_q <= run_q + 6'h01;
      end
    end
  end

  // ==========================================================
  // Edge selection
  logic rise, fall, detect;
  always_ff @(posedge clock_in) begin
    if (rst_in) prev_q <= 1'b1;
    else prev_q <= acc_q;
  end
  assign rise = acc_q & ~prev_q;
  assign fall = ~acc_q & prev_q;
  // Codes two and three both select either edge.
  assign detect = (ch.edge_select == `TST_EDGE_FALL) ? fall :
                  (ch.edge_select == `TST_EDGE_RISE) ? rise :
                  (rise | fall); // [R7]

  // ==========================================================
  // Saturating event counter
  tst_pkg::tst_count_t cnt_q;
  // An event in the clearing cycle survives as a count of one.
  always_ff @(posedge clock_in) begin
    if (rst_in) cnt_q <= 6'h00;
    else if (ch.count_clear) cnt_q <= detect ? 6'h01 : 6'h00;
    else if (detect && cnt_q != `TST_CNT_MAX)
      cnt_q <= cnt_q + 6'h01; // [R8] [R9]
  end
  assign ch.count = cnt_q;

  // ==========================================================
  // Fetch delay
  tst_pkg::tst_fetch_state_t state_q;
  logic [`TST_TIMER_W-1:0] timer_q, wait_len_q;
  logic fire_q;
  // Events during the wait are counted but share one capture.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= tst_pkg::TST_FETCH_IDLE;
      timer_q <= '0;
      fire_q <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      case (state_q)
        tst_pkg::TST_FETCH_IDLE: begin
          if (detect) begin
            state_q <= tst_pkg::TST_FETCH_WAIT;
            timer_q <= `TST_TIMER_W'(FETCH_CYC - 1);
          end
        end
        tst_pkg::TST_FETCH_WAIT: begin
          if (timer_q == '0) begin
            fire_q <= 1'b1; // [R6]
            state_q <= tst_pkg::TST_FETCH_IDLE;
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        default: state_q <= tst_pkg::TST_FETCH_IDLE;
      endcase
    end
  end
  assign ch.fire = fire_q;

  // Helper that measures the wait for the checks below.
  always_ff @(posedge clock_in) begin
    if (rst_in || state_q == tst_pkg::TST_FETCH_IDLE) wait_len_q <= '0;
    else wait_len_q <= wait_len_q + 1'b1;
  end

  // ==========================================================
  // Checks
  fetch_delay_a: assert property (@(posedge clock_in) // [R6]
    disable iff (rst_in)
    fire_q |-> wait_len_q == `TST_TIMER_W'(FETCH_CYC))
    else $error("capture fetch delay wrong");
  cnt_step_a: assert property (@(posedge clock_in) disable iff (rst_in) // [R8]
    detect && !ch.count_clear && cnt_q != `TST_CNT_MAX
    |=> cnt_q == $past(cnt_q) + 6'h01)
    else $error("event counter missed a step");
  cnt_sat_a: assert property (@(posedge clock_in) disable iff (rst_in) // [R9]
    cnt_q == `TST_CNT_MAX && !ch.count_clear |=> cnt_q == `TST_CNT_MAX)
    else $error("event counter left 63");
  filter_hold_a: assert property (@(posedge clock_in) // [R2]
    disable iff (rst_in)
    ch.filter_count != `TST_FILT_BYPASS && !ch.sample_tick |=> $stable(acc_q))
    else $error("filter moved between samples");
  monitor_a: assert property (@(posedge clock_in) disable iff (rst_in) // [R10]
    s2_q == s3_q |=> level_q == $past(s3_q))
    else $error("monitor level wrong");
  sequence rise_seen_s;
    !acc_q ##1 acc_q;
  endsequence
  edge_rise_a: assert property (@(posedge clock_in) // [R7]
    disable iff (rst_in)
    ch.edge_select == `TST_EDGE_RISE && state_q == tst_pkg::TST_FETCH_IDLE
    ##0 rise_seen_s |=> state_q == tst_pkg::TST_FETCH_WAIT)
    else $error("rising edge not detected");
endmodule : tst_pin_channel

// >>> verilog/tst_trigger_top.sv
/*
 * Time-stamp trigger front end: three event pins, internal detector
 * triggers, command trigger and the 256-byte record buffer.
 * Assumes detector levels are asynchronous and the time stamp,
 * configuration and command strobe are on clock_in.
 */
`timescale 1ns/10ps
`include "tst_consts.svh"
module tst_trigger_top #(
  parameter int unsigned SAMPLE_CYC = `TST_SAMPLE_MS * `TST_CLK_KHZ,
  parameter int unsigned FETCH_CYC = `TST_FETCH_MS * `TST_CLK_KHZ
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic event_input_pin_one_in,
  input wire logic event_input_pin_two_in,
  input wire logic event_input_pin_three_in,
  input wire logic [2:0] input_one_pull_select_in,
  input wire logic [2:0] input_two_pull_select_in,
  input wire logic [2:0] input_three_pull_select_in,
  input wire logic [1:0] input_one_edge_select_in,
  input wire logic [1:0] input_two_edge_select_in,
  input wire logic [1:0] input_three_edge_select_in,
  input wire logic [5:0] input_one_filter_in,
  input wire logic [5:0] input_two_filter_in,
  input wire logic [5:0] input_three_filter_in,
  input wire logic [2:0] counter_clear_in,
  input wire logic battery_drop_in,
  input wire logic supply_threshold_one_drop_in,
  input wire logic supply_threshold_two_drop_in,
  input wire logic osc_stop_in,
  input wire logic switch_init_enable_in,
  input wire logic command_trigger_enable_in,
  input wire logic command_trigger_write_in,
  input wire logic [`TST_TS_BITS-1:0] timestamp_in,
  input wire logic [`TST_PTR_W-1:0] record_read_index_in,
  output logic [3:0] input_one_pull_out,
  output logic [3:0] input_two_pull_out,
  output logic [3:0] input_three_pull_out,
  output logic [5:0] input_one_counter_out,
  output logic [5:0] input_two_counter_out,
  output logic [5:0] input_three_counter_out,
  output logic [2:0] pin_level_monitor_out,
  output logic capture_strobe_out,
  output logic [7:0] capture_factor_out,
  output logic [`TST_PTR_W-1:0] record_write_index_out,
  output logic [63:0] record_read_data_out
);
  // ==========================================================
  // Sample tick
  logic [`TST_TIMER_W-1:0] tick_cnt_q;
  logic tick_q;
  // One pulse every 125 ms drives all pin filters.
  always_ff @(posedge clock_in) begin
    if (rst_in || tick_cnt_q == `TST_TIMER_W'(SAMPLE_CYC - 1)) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
    tick_q <= !rst_in && tick_cnt_q == `TST_TIMER_W'(SAMPLE_CYC - 1); // [R2]
  end

  // ==========================================================
  // Pin channels
  logic [2:0] pins, clears;
  logic [2:0][2:0] pull_sel;
  logic [2:0][1:0] edge_sel;
  logic [2:0][5:0] filt;
  logic [2:0][3:0] pull_q;
  logic [2:0][5:0] counts;
  logic [2:0] levels, fires;
  assign pins = {event_input_pin_three_in, event_input_pin_two_in,
                 event_input_pin_one_in};
  assign pull_sel = {input_three_pull_select_in, input_two_pull_select_in,
                     input_one_pull_select_in};
  assign edge_sel = {input_three_edge_select_in, input_two_edge_select_in,
                     input_one_edge_select_in};
  assign filt = {input_three_filter_in, input_two_filter_in,
                 input_one_filter_in};
  assign clears = counter_clear_in;
  tst_chan_if ch[3] ();
  genvar g;
  for (g = 0; g < 3; g++) begin : gen_pin
    assign ch[g].sample_tick = tick_q;
    assign ch[g].filter_count = filt[g];
    assign ch[g].edge_select = edge_sel[g];
    assign ch[g].count_clear = clears[g];
    assign levels[g] = ch[g].level;
    assign counts[g] = ch[g].count;
    assign fires[g] = ch[g].fire;
    tst_pin_channel #(.FETCH_CYC(FETCH_CYC)) tst_pin_channel_i (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .pin_in(pins[g]),
      .ch(ch[g].chan)
    );
    // Pull enables: bit 0 up 500k, 1 up 1M, 2 up 10M, 3 down 500k.
    always_ff @(posedge clock_in) begin
      if (rst_in) pull_q[g] <= `TST_PEN_UP_1M;
      else begin
        case (pull_sel[g])
          `TST_PULL_UP_500K: pull_q[g] <= `TST_PEN_UP_500K; // [R1]
          `TST_PULL_UP_1M: pull_q[g] <= `TST_PEN_UP_1M;
          `TST_PULL_UP_10M: pull_q[g] <= `TST_PEN_UP_10M;
          `TST_PULL_DN_500K: pull_q[g] <= `TST_PEN_DN_500K;
          default: pull_q[g] <= `TST_PEN_NONE;
        endcase
      end
    end
  end
  assign input_one_pull_out = pull_q[0];
  assign input_two_pull_out = pull_q[1];
  assign input_three_pull_out = pull_q[2];
  assign input_one_counter_out = counts[0];
  assign input_two_counter_out = counts[1];
  assign input_three_counter_out = counts[2];
  assign pin_level_monitor_out = levels;

  // ==========================================================
  // Internal detectors
  logic [3:0] det_raw, det_s1_q, det_s2_q, det_s3_q, det_q, det_prev_q;
  assign det_raw = {battery_drop_in, supply_threshold_two_drop_in,
                    supply_threshold_one_drop_in, osc_stop_in};
  for (g = 0; g < 4; g++) begin : gen_det
    // Three-stage synchroniser; level moves when stages two and three agree.
    always_ff @(posedge clock_in) begin
      if (rst_in) begin
        det_s1_q[g] <= 1'b0;
        det_s2_q[g] <= 1'b0;
        det_s3_q[g] <= 1'b0;
        det_q[g] <= 1'b0;
        det_prev_q[g] <= 1'b0;
      end else begin
        det_s1_q[g] <= det_raw[g];
        det_s2_q[g] <= det_s1_q[g];
        det_s3_q[g] <= det_s2_q[g];
        if (det_s2_q[g] == det_s3_q[g]) det_q[g] <= det_s3_q[g];
        det_prev_q[g] <= det_q[g];
      end
    end
  end

  // Oscillation stop waits for the oscillator to resume.
  tst_pkg::tst_osc_state_t osc_q;
  logic osc_fire;
  always_ff @(posedge clock_in) begin
    if (rst_in) osc_q <= tst_pkg::TST_OSC_RUN;
    else begin
      case (osc_q)
        tst_pkg::TST_OSC_RUN:
          if (det_q[`TST_F_OSC]) osc_q <= tst_pkg::TST_OSC_STOPPED;
        tst_pkg::TST_OSC_STOPPED:
          if (!det_q[`TST_F_OSC]) osc_q <= tst_pkg::TST_OSC_RUN; // [R12]
        default: osc_q <= tst_pkg::TST_OSC_RUN;
      endcase
    end
  end
  assign osc_fire = osc_q == tst_pkg::TST_OSC_STOPPED && !det_q[`TST_F_OSC];

  // ==========================================================
  // Trigger merge and capture
  logic [7:0] factor;
  logic [2:0] vdrop;
  assign vdrop = det_q[`TST_F_VBAT:`TST_F_SUPPLY_THRESHOLD_ONE] &
                 ~det_prev_q[`TST_F_VBAT:`TST_F_SUPPLY_THRESHOLD_ONE];
  always_comb begin
    factor = 8'h00;
    factor[`TST_F_OSC] = osc_fire; // [R11]
    factor[`TST_F_VBAT:`TST_F_SUPPLY_THRESHOLD_ONE] =
        vdrop & {3{switch_init_enable_in}}; // [R11] [R13]
    factor[`TST_F_PIN+2:`TST_F_PIN] = fires;
    factor[`TST_F_CMD] = command_trigger_write_in &&
                         command_trigger_enable_in; // [R14] [R15]
  end

  tst_pkg::tst_record_t mem [`TST_REC_ENTRIES];
  logic [`TST_PTR_W-1:0] wr_ptr_q;
  logic strobe_q;
  logic [7:0] factor_q;
  // Simultaneous triggers share one record; the index wraps at the end.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      strobe_q <= 1'b0;
      factor_q <= 8'h00;
    end else begin
      strobe_q <= |factor; // [R17]
      if (|factor) begin
        factor_q <= factor;
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
    end
  end
  // Buffer storage, 32 records of eight bytes.
  always_ff @(posedge clock_in) begin
    if (|factor) mem[wr_ptr_q] <= {timestamp_in, factor}; // [R16] [R17]
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) record_read_data_out <= '0;
    else record_read_data_out <= mem[record_read_index_in];
  end
  assign capture_strobe_out = strobe_q;
  assign capture_factor_out = factor_q;
  assign record_write_index_out = wr_ptr_q;

  // ==========================================================
  // Checks
  cmd_fire_a: assert property (@(posedge clock_in) disable iff (rst_in) // [R14]
    command_trigger_write_in && command_trigger_enable_in
    |=> strobe_q && factor_q[`TST_F_CMD])
    else $error("command trigger lost");
  cmd_block_a: assert property (@(posedge clock_in) // [R15]
    disable iff (rst_in)
    strobe_q && factor_q[`TST_F_CMD] |-> $past(command_trigger_enable_in))
    else $error("command trigger while disabled");
  vdrop_gate_a: assert property (@(posedge clock_in) // [R13]
    disable iff (rst_in)
    strobe_q && |factor_q[`TST_F_VBAT:`TST_F_SUPPLY_THRESHOLD_ONE]
    |-> $past(switch_init_enable_in))
    else $error("supply drop trigger while disabled");
  osc_resume_a: assert property (@(posedge clock_in) // [R12]
    disable iff (rst_in)
    strobe_q && factor_q[`TST_F_OSC] |-> $past(!det_q[`TST_F_OSC])
    && $past(osc_q) == tst_pkg::TST_OSC_STOPPED)
    else $error("oscillation stop captured early");
  buf_write_a: assert property (@(posedge clock_in) // [R17]
    disable iff (rst_in)
    |factor |=> strobe_q && wr_ptr_q == $past(wr_ptr_q) + 1'b1)
    else $error("record not written");
  tick_period_a: assert property (@(posedge clock_in) // [R2]
    disable iff (rst_in)
    tick_q |=> !tick_q)
    else $error("sample tick wider than a cycle");
endmodule : tst_trigger_top
